// >>> include/gdpi_pkg.sv
// package for the gpio drive strength and port 0 pin interrupt block
package gdpi_pkg;

  // special function register offsets
  localparam logic [7:0] OFS_P0_DRIVE = 8'hc1;
  localparam logic [7:0] OFS_P1_DRIVE = 8'hc2;
  localparam logic [7:0] OFS_P3_DRIVE = 8'hc4;
  localparam logic [7:0] OFS_PORT0_IRQ_POLARITY = 8'hea;
  localparam logic [7:0] OFS_P0_MODE = 8'heb;
  localparam logic [7:0] OFS_P0_EN = 8'hec;
  localparam logic [7:0] OFS_P0_PEND = 8'hed;
  localparam logic [7:0] OFS_PORT1_IRQ_POLARITY = 8'hf2;

  // reset values
  localparam logic [7:0] RST_DRIVE = 8'h00;
  localparam logic [7:0] RST_IRQ_CFG = 8'h00;
  localparam logic [7:0] RST_PEND = 8'h00;

  // port 1 drive bits 5 and 2 are not implemented
  localparam logic [7:0] P1_DRIVE_MASK = 8'hdb;
  // port 0 pins 7..5 are the 4/8 mA group, 4..0 the 12/16 mA group
  localparam logic [7:0] P0_LOWGRP_MASK = 8'he0;

  // interrupt vector addresses
  localparam logic [7:0] VEC_NORMAL = 8'h83;
  localparam logic [7:0] VEC_WAKEUP = 8'h7b;

  // drive strength codes, one per pin
  typedef enum logic [1:0] {
    GDPI_DRV_4MA,
    GDPI_DRV_8MA,
    GDPI_DRV_12MA,
    GDPI_DRV_16MA
  } gdpi_drive_t;

  // register bus request from the core
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gdpi_sfr_req_t;

  // whole block state
  typedef struct packed {
    logic [7:0] p0_drive;
    logic [7:0] p1_drive;
    logic [7:0] p3_drive;
    logic [7:0] port0_irq_polarity;
    logic [7:0] p0_mode;
    logic [7:0] p0_en;
    logic [7:0] p0_pend;
    logic [7:0] port1_irq_polarity;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] prev;
    logic [7:0] rdata;
  } gdpi_state_t;

endpackage

// >>> core/gdpi_top.sv
// drive strength selection and port 0 pin interrupt logic
`timescale 1ns/10ps
module gdpi_top (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // special function register bus
  input wire gdpi_pkg::gdpi_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  // power mode, high while in power-down
  input wire logic power_down,
  // port 0 pins
  input wire logic [7:0] port0_pin,
  // drive strength per pin
  output gdpi_pkg::gdpi_drive_t port0_drive [8],
  output gdpi_pkg::gdpi_drive_t port1_drive [8],
  output gdpi_pkg::gdpi_drive_t port3_drive [8],
  // interrupt request and its vector
  output logic pin_irq,
  output logic [7:0] pin_irq_vector
);
  import gdpi_pkg::*;

  gdpi_state_t s_q;
  gdpi_state_t s_d;
  logic [7:0] act;
  logic [7:0] edge_hit;
  logic [7:0] trig;
  logic [7:0] clr;

  // address decode used only for sfr_hit; the read and write paths decode with their own case statements
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == OFS_P0_DRIVE) || (a == OFS_P1_DRIVE) || (a == OFS_P3_DRIVE) ||
                (a == OFS_PORT0_IRQ_POLARITY) || (a == OFS_P0_MODE) || (a == OFS_P0_EN) ||
                (a == OFS_P0_PEND) || (a == OFS_PORT1_IRQ_POLARITY);
  endfunction

  // level and edge detection on the second sync stage only
  always_comb begin
    act = ~(s_q.sync2 ^ s_q.port0_irq_polarity);
    edge_hit = act & ~(~(s_q.prev ^ s_q.port0_irq_polarity));
    trig = (s_q.p0_mode & edge_hit) | (~s_q.p0_mode & act);
    trig = trig & s_q.p0_en & {8{~power_down}};
    clr = (sfr_req.wr && sfr_req.addr == OFS_P0_PEND) ? sfr_req.wdata : 8'h00;
  end

  // next state
  always_comb begin
    s_d = s_q;
    s_d.sync1 = port0_pin;
    s_d.sync2 = s_q.sync1;
    s_d.prev = s_q.sync2;
    // set wins over a clear in the same cycle; level mode re-sets while active
    s_d.p0_pend = (s_q.p0_pend & ~clr) | trig;
    if (sfr_req.wr) begin
      case (sfr_req.addr)
        OFS_P0_DRIVE: s_d.p0_drive = sfr_req.wdata;
        OFS_P1_DRIVE: s_d.p1_drive = sfr_req.wdata & P1_DRIVE_MASK;
        OFS_P3_DRIVE: s_d.p3_drive = sfr_req.wdata;
        OFS_PORT0_IRQ_POLARITY: s_d.port0_irq_polarity = sfr_req.wdata;
        OFS_P0_MODE: s_d.p0_mode = sfr_req.wdata;
        OFS_P0_EN: s_d.p0_en = sfr_req.wdata;
        OFS_PORT1_IRQ_POLARITY: s_d.port1_irq_polarity = sfr_req.wdata;
        default: s_d.p0_drive = s_d.p0_drive;
      endcase
    end
    // read data registered; unmapped reads return zero
    case (sfr_req.addr)
      OFS_P0_DRIVE: s_d.rdata = s_q.p0_drive;
      OFS_P1_DRIVE: s_d.rdata = s_q.p1_drive;
      OFS_P3_DRIVE: s_d.rdata = s_q.p3_drive;
      OFS_PORT0_IRQ_POLARITY: s_d.rdata = s_q.port0_irq_polarity;
      OFS_P0_MODE: s_d.rdata = s_q.p0_mode;
      OFS_P0_EN: s_d.rdata = s_q.p0_en;
      OFS_P0_PEND: s_d.rdata = s_q.p0_pend;
      OFS_PORT1_IRQ_POLARITY: s_d.rdata = s_q.port1_irq_polarity;
      default: s_d.rdata = 8'h00;
    endcase
  end

  // state register, synchronous reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.p0_drive <= RST_DRIVE;
      s_q.p1_drive <= RST_DRIVE;
      s_q.p3_drive <= RST_DRIVE;
      s_q.port0_irq_polarity <= RST_IRQ_CFG;
      s_q.p0_mode <= RST_IRQ_CFG;
      s_q.p0_en <= RST_IRQ_CFG;
      s_q.p0_pend <= RST_PEND;
      s_q.port1_irq_polarity <= RST_IRQ_CFG;
    end else begin
      s_q <= s_d;
    end
  end

  // per-pin drive codes
  for (genvar i = 0; i < 8; i++) begin : g_drive
    if (P0_LOWGRP_MASK[i]) begin : g_low
      assign port0_drive[i] = s_q.p0_drive[i] ? GDPI_DRV_8MA : GDPI_DRV_4MA;
    end else begin : g_high
      assign port0_drive[i] = s_q.p0_drive[i] ? GDPI_DRV_16MA : GDPI_DRV_12MA;
    end
    assign port1_drive[i] = s_q.p1_drive[i] ? GDPI_DRV_8MA : GDPI_DRV_4MA;
    assign port3_drive[i] = s_q.p3_drive[i] ? GDPI_DRV_8MA : GDPI_DRV_4MA;
  end

  // outputs; pull controls live elsewhere in external data space
  assign sfr_rdata = s_q.rdata;
  assign sfr_hit = is_mapped(sfr_req.addr) & (sfr_req.wr | sfr_req.rd);
  assign pin_irq = |s_q.p0_pend;
  // wakeup vector shown in power-down, normal vector otherwise
  assign pin_irq_vector = power_down ? VEC_WAKEUP : VEC_NORMAL;
endmodule

// >>> tb/gdpi_pins.sv
// stand-in for the external circuits on the port 0 pins
`timescale 1ns/10ps
module gdpi_pins (
  // levels asked for
  input wire logic [7:0] want,
  // port 0 pins
  output logic [7:0] pins
);
  // pins are push-pull, so the wanted level is the wire level
  assign pins = want;
endmodule

// >>> tb/gdpi_top_properties.sv
// port assertions for the drive and pin interrupt block
`timescale 1ns/10ps
module gdpi_top_properties (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // bus and mode
  input wire gdpi_pkg::gdpi_sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire logic power_down,
  // request
  input wire logic pin_irq,
  input wire logic [7:0] pin_irq_vector
);
  import gdpi_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_VEC_RUN: assert property (!power_down |-> pin_irq_vector == 8'h83)
    else $error("vector");
  AST_VEC_PD: assert property (power_down |-> pin_irq_vector == 8'h7b)
    else $error("wake vector");
  AST_RST: assert property (disable iff (1'b0) !nrst |=> !pin_irq && !sfr_rdata)
    else $error("reset");
  AST_UNMAP: assert property (sfr_req.addr == 8'h00 |=> sfr_rdata == 8'h00)
    else $error("unmapped");
  AST_P1_RSV: assert property (sfr_req.addr == 8'hc2 |=> (sfr_rdata & 8'h24) == 8'h00)
    else $error("reserved");
  AST_OR: assert property (sfr_req.addr == 8'hed |=> (sfr_rdata != 0) == $past(pin_irq))
    else $error("or");
  AST_W0: assert property (sfr_req.wr && sfr_req.addr == 8'hed && !sfr_req.wdata
    && pin_irq |=> pin_irq) else $error("zero write");
  // a new flag in power-down would wrongly raise the request
  AST_PD: assert property (power_down && !pin_irq |=> !pin_irq)
    else $error("power-down");
endmodule
bind gdpi_top gdpi_top_properties gdpi_top_properties_i (.clk(clk), .nrst(nrst),
  .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .power_down(power_down), .pin_irq(pin_irq),
  .pin_irq_vector(pin_irq_vector));

// >>> tb/gdpi_top_tb.sv
// bench for the drive and pin interrupt block
`timescale 1ns/10ps
module gdpi_top_tb;
  import gdpi_pkg::*;
  logic clk = 0, nrst = 0, power_down = 0, pin_irq, hit;
  logic [7:0] want = 8'hff, v, a, pins, sfr_rdata, pin_irq_vector;
  gdpi_sfr_req_t sfr_req = '0;
  gdpi_drive_t port0_drive [8], port1_drive [8], port3_drive [8];
  logic [7:0] ofs [8] = '{OFS_P0_DRIVE, OFS_P1_DRIVE, OFS_P3_DRIVE, OFS_PORT0_IRQ_POLARITY, OFS_P0_MODE,
    OFS_P0_EN, OFS_P0_PEND, OFS_PORT1_IRQ_POLARITY};
  int err_total = 0, compares = 0;
  always #4 clk = ~clk;
  gdpi_pins gdpi_pins_i (.want(want), .pins(pins));
  gdpi_top gdpi_top_i (.clk(clk), .nrst(nrst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .sfr_hit(hit), .power_down(power_down), .port0_pin(pins), .port0_drive(port0_drive),
    .port1_drive(port1_drive), .port3_drive(port3_drive), .pin_irq(pin_irq),
    .pin_irq_vector(pin_irq_vector));
  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic print_verdict();
    if (err_total == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // strobe left up so back-to-back calls never assign twice in one step
  task automatic acc(logic w, logic [7:0] ad, logic [7:0] d);
    sfr_req = '{w, !w, ad, d};
    @(posedge clk) #1;
  endtask
  // move pins, wait out the two-flop sync, then read the flags
  task automatic pend(logic [7:0] p, logic [7:0] e);
    sfr_req = '0;
    want = p;
    repeat (4) @(posedge clk);
    #1 acc(0, OFS_P0_PEND, 0);
    chk("pending", e, sfr_rdata);
    chk("irq", {7'h0, e != 0}, pin_irq);
    chk("vector", power_down ? 8'h7b : 8'h83, pin_irq_vector);
  endtask
  initial begin
    void'($urandom(32'haf52));
    repeat (2) @(posedge clk);
    #1 nrst = 1;
    for (int k = 0; k < 8; k++) begin
      a = ofs[k];
      acc(0, a, 0);
      chk("reset", 8'h00, sfr_rdata);
      chk("hit", 8'h01, {7'h0, hit});
      v = 8'($urandom);
      acc(1, a, v);
      acc(0, a, 0);
      if (a != OFS_P0_PEND) chk("rw", a == OFS_P1_DRIVE ? v & P1_DRIVE_MASK : v, sfr_rdata);
    end
    acc(1, 8'h00, 8'hff);
    chk("unmapped hit", 8'h00, {7'h0, hit});
    acc(0, 8'h00, 0);
    chk("unmapped", 8'h00, sfr_rdata);
    v = 8'($urandom);
    acc(1, OFS_P0_DRIVE, v);
    acc(1, OFS_P1_DRIVE, v);
    acc(1, OFS_P3_DRIVE, ~v);
    for (int i = 0; i < 8; i++) begin
      chk("p0 drive", {i < 5, v[i]}, port0_drive[i]);
      chk("p1 drive", {1'b0, v[i] & P1_DRIVE_MASK[i]}, port1_drive[i]);
      chk("p3 drive", {1'b0, !v[i]}, port3_drive[i]);
    end
    // pin 0 level low, pin 1 falling edge, pin 2 disabled
    acc(1, OFS_P0_EN, 0);
    acc(1, OFS_PORT0_IRQ_POLARITY, 0);
    acc(1, OFS_P0_MODE, 8'h02);
    acc(1, OFS_P0_PEND, 8'hff);
    acc(1, OFS_P0_EN, 8'h03);
    pend(8'hf8, 8'h03);
    acc(1, OFS_P0_PEND, 8'h00);
    acc(1, OFS_P0_PEND, 8'hff);
    pend(8'hf8, 8'h01);
    acc(1, OFS_P0_PEND, 8'hff);
    // flag re-set while the pin was still low, so it stays until cleared again
    pend(8'hff, 8'h01);
    acc(1, OFS_P0_PEND, 8'hff);
    pend(8'hff, 8'h00);
    power_down = 1;
    pend(8'hf8, 8'h00);
    power_down = 0;
    pend(8'hf8, 8'h01);
    acc(1, OFS_PORT0_IRQ_POLARITY, 8'h01);
    acc(1, OFS_P0_PEND, 8'hff);
    pend(8'hf8, 8'h00);
    print_verdict();
  end
endmodule
